// ---- sysctl_defs.svh ----
// Purpose: Offsets, field positions and reset values of the endian and
//          interface configuration registers.
// Assumes: Word registers addressed by byte offset inside the reset block.
// Notes:   Definitions only.
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

// Register byte offsets
`define OFS_BYTESWAP      8'h0C
`define OFS_NMI           8'h10
`define OFS_REV           8'h14
`define OFS_IF_CTL        8'h18

// Byteswap register: writable bit mask and CPU endian reset default
`define BYTESWAP_MASK     32'h0007_9E78
`define CPU_BIG_END_RST   1'b1

// Byteswap field positions
`define BS_PCI_EP_SWAP    3
`define BS_SDRAM_BIG      4
`define BS_LBUS_SWAP      5
`define BS_ENET_SWAP      6
`define BS_WBUF_MERGE     9
`define BS_CPU_BIG        10
`define BS_PCI_TGT_SWAP   11
`define BS_PCI_TGT_BIG    12
`define BS_FLASH_SWAP     15
`define BS_DRAM_SWAP      16
`define BS_PCI_EXT_SWAP   17
`define BS_MAPREG_SWAP    18

// Interface control fields and NMI trigger bit
`define IF_HOST_BIT       4
`define IF_WIDTH          16
`define NMI_TRIG_BIT      0

// Interface enable values
`define IFEN_NONE         3'h0
`define IFEN_PCI          3'h1
`define IFEN_LBUS         3'h2
`define IFEN_BOTH         3'h3

// Strap values
`define STRAP_PCI_CLIENT  2'h0
`define STRAP_LBUS        2'h1
`define STRAP_RADIO_TEST  2'h2
`define STRAP_PCI_HOST    2'h3

// Peripheral bus timeout length while enabled
`define APB_TIMEOUT_CYC   8192

`endif

// ---- sysctl_pkg.sv ----
// Purpose: Types shared by the endian and interface configuration block.
// Assumes: Field order of the structs matches register bit order.
// Notes:   Byteswap fields are listed from bit 18 down to bit 3.
package sysctl_pkg;

  // Byteswap and endian controls, one bit per field
  typedef struct packed {
    logic cpu_mapreg_swap;
    logic cpu_pci_ext_swap;
    logic cpu_dram_swap;
    logic cpu_flash_swap;
    logic pci_tgt_big_endian;
    logic pci_tgt_swap;
    logic cpu_big_endian;
    logic wbuf_full_merge;
    logic enet_swap;
    logic lbus_swap;
    logic sdram_big_endian;
    logic pci_ep_swap;
  } swap_ctl_t;

  // Interface control, bits 15 down to 0
  typedef struct packed {
    logic       intr_host_sel;
    logic       apb_timeout_off;
    logic [2:0] apb_obs_sel;
    logic [2:0] ahb_obs_sel;
    logic [1:0] dsl_obs_sel;
    logic       intr_en;
    logic       pci_host;
    logic       lbus_host;
    logic [2:0] if_enable;
  } if_ctl_t;

  // Strap capture sequence after reset
  typedef enum logic [1:0] {
    ST_FILL1,
    ST_FILL2,
    ST_LOAD,
    ST_RUN
  } strap_state_t;

endpackage

// ---- sysctl_cfg.sv ----
// Purpose: Endian, byteswap, NMI, revision and interface control registers.
// Assumes: Register port on mclk; straps are board levels, asynchronous.
// Notes:   Straps pass a two-stage synchroniser before they load fields.
// Function
// - Bit 3 swaps PCI endpoint master data
// - Bit 4 drives SDRAM controller endian
// - Bit 5 swaps local bus master data
// - Bit 6 swaps Ethernet master data
// - Bit 9 selects write buffer merge
// - Bit 10 CPU endian, resets big
// - Bit 11 swaps PCI target master data
// - Bit 12 PCI target bridge endian
// - Bit 15 swaps CPU flash regions
// - Bit 16 swaps CPU DRAM region
// - Bit 17 swaps CPU PCI region
// - Bit 18 swaps CPU register region
// - NMI write one pulses, reads zero
// - Bits 2:0 select enabled interfaces
// - Enable field loads from mode strap
// - Bit 3 local bus host, strap reset
// - Bit 4 PCI host, strap reset; setting it needs availability
// - Bits 5,15 gate PCI interrupt
// - Bits 7:6 select observation source
// - Bits 10:8 system bus observation
// - Bits 13:11 peripheral bus observation
// - Bit 14 disables peripheral timeout

`timescale 1ns/10ps
`include "sysctl_defs.svh"

module sysctl_cfg
  import sysctl_pkg::*;
#(
  parameter logic [3:0] REV_LEVEL = 4'h1, // Arbitrary value
  parameter logic [3:0] VER_LEVEL = 4'h2  // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [1:0]  mode_strap,
  input  wire logic        eeprom_en_strap,
  input  wire logic        pci_available,
  input  wire logic [31:0] global_irq_status,
  input  wire logic [31:0] client_irq_mask,
  input  wire logic [31:0] pci_irq_status,
  input  wire logic [31:0] pci_host_irq_mask,
  input  wire logic [31:0] pci_host_irq_enable,
  output swap_ctl_t        swap_ctl,
  output if_ctl_t          if_ctl,
  output logic             cpu_nmi_pulse,
  output logic             pci_inta_req,
  output logic             apb_timeout_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Address match, shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Strap code to interface enable value
  function automatic logic [2:0] strap_if_enable(input logic [1:0] s);
    if (s == `STRAP_PCI_CLIENT) begin
      strap_if_enable = `IFEN_PCI;
    end else if (s == `STRAP_LBUS) begin
      strap_if_enable = `IFEN_LBUS;
    end else if (s == `STRAP_RADIO_TEST) begin
      strap_if_enable = `IFEN_NONE;
    end else begin
      strap_if_enable = `IFEN_PCI;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser and capture

  logic [1:0]   mode_meta_r;
  logic [1:0]   mode_sync_r;
  logic         eep_meta_r;
  logic         eep_sync_r;
  strap_state_t strap_st_r;
  strap_state_t strap_st_nxt;
  logic         strap_load;

  // Two flops per strap; first stage is read only by the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_meta_r <= 2'h0;
      mode_sync_r <= 2'h0;
      eep_meta_r  <= 1'b0;
      eep_sync_r  <= 1'b0;
    end else begin
      mode_meta_r <= mode_strap;
      mode_sync_r <= mode_meta_r;
      eep_meta_r  <= eeprom_en_strap;
      eep_sync_r  <= eep_meta_r;
    end
  end

  // Wait for the synchroniser to fill, then load once
  always_comb begin
    case (strap_st_r)
      ST_FILL1: strap_st_nxt = ST_FILL2;
      ST_FILL2: strap_st_nxt = ST_LOAD;
      ST_LOAD:  strap_st_nxt = ST_RUN;
      default:  strap_st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_st_r <= ST_FILL1;
    end else begin
      strap_st_r <= strap_st_nxt;
    end
  end

  // strap static
  // Straps are sampled once only; a later board change is not followed
  assign strap_load = (strap_st_r == ST_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  logic wr_bs;
  logic wr_nmi;
  logic wr_if;

  always_comb begin
    wr_bs  = 1'b0;
    wr_nmi = 1'b0;
    wr_if  = 1'b0;
    if (reg_wr && hit(reg_addr, `OFS_BYTESWAP)) begin
      wr_bs = 1'b1;
    end else if (reg_wr && hit(reg_addr, `OFS_NMI)) begin
      wr_nmi = 1'b1;
    end else if (reg_wr && hit(reg_addr, `OFS_IF_CTL)) begin
      wr_if = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byteswap and endian register

  logic [31:0] bs_r;
  logic [31:0] bs_rst_val;

  // endian default
  // Fields that follow the CPU endian default take bit 10's reset value
  always_comb begin
    bs_rst_val = 32'h0000_0000;
    bs_rst_val[`BS_PCI_EP_SWAP] = `CPU_BIG_END_RST;
    bs_rst_val[`BS_LBUS_SWAP]   = `CPU_BIG_END_RST;
    bs_rst_val[`BS_ENET_SWAP]   = `CPU_BIG_END_RST;
    bs_rst_val[`BS_CPU_BIG]     = `CPU_BIG_END_RST;
    bs_rst_val[`BS_FLASH_SWAP]  = `CPU_BIG_END_RST;
  end

  // reserved masked
  // Only documented bits are stored; the rest stay zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      bs_r <= bs_rst_val;
    end else if (wr_bs) begin
      bs_r <= reg_wdata & `BYTESWAP_MASK;
    end
  end

  assign swap_ctl.pci_ep_swap        = bs_r[`BS_PCI_EP_SWAP];
  assign swap_ctl.sdram_big_endian   = bs_r[`BS_SDRAM_BIG];
  assign swap_ctl.lbus_swap          = bs_r[`BS_LBUS_SWAP];
  assign swap_ctl.enet_swap          = bs_r[`BS_ENET_SWAP];
  assign swap_ctl.wbuf_full_merge    = bs_r[`BS_WBUF_MERGE];
  assign swap_ctl.cpu_big_endian     = bs_r[`BS_CPU_BIG];
  assign swap_ctl.pci_tgt_swap       = bs_r[`BS_PCI_TGT_SWAP];
  assign swap_ctl.pci_tgt_big_endian = bs_r[`BS_PCI_TGT_BIG];
  assign swap_ctl.cpu_flash_swap     = bs_r[`BS_FLASH_SWAP];
  assign swap_ctl.cpu_dram_swap      = bs_r[`BS_DRAM_SWAP];
  assign swap_ctl.cpu_pci_ext_swap   = bs_r[`BS_PCI_EXT_SWAP];
  assign swap_ctl.cpu_mapreg_swap    = bs_r[`BS_MAPREG_SWAP];

  ////////////////////////////////////////////////////////////////////////////
  // NMI pulse

  // NMI pulse
  // One cycle per write of one; a write of zero does nothing
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_nmi_pulse <= 1'b0;
    end else begin
      cpu_nmi_pulse <= wr_nmi & reg_wdata[`NMI_TRIG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interface control register

  if_ctl_t if_r;
  if_ctl_t if_wr;

  // host guarded
  // A written one only lands in the host bit while PCI is available
  always_comb begin
    if_wr = if_ctl_t'(reg_wdata[`IF_WIDTH-1:0]);
    if (reg_wdata[`IF_HOST_BIT] && !pci_available) begin
      if_wr.pci_host = if_r.pci_host;
    end
  end

  // Strap load wins over a write landing in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      if_r <= '0;
    end else if (strap_load) begin
      if_r.if_enable <= strap_if_enable(mode_sync_r);
      if_r.lbus_host <= eep_sync_r;
      if_r.pci_host  <= mode_sync_r[1] & mode_sync_r[0];
    end else if (wr_if) begin
      // enable field
      // Reserved codes 4 to 7 are stored; users treat them as none
      // DSL observation select
      if_r <= if_wr;
    end
  end

  assign if_ctl = if_r;

  // timeout enable
  // The peripheral bus times out after APB_TIMEOUT_CYC while enabled
  assign apb_timeout_en = ~if_r.apb_timeout_off;

  ////////////////////////////////////////////////////////////////////////////
  // PCI interrupt gating

  logic client_irq;
  logic host_irq;

  assign client_irq = |(global_irq_status & client_irq_mask);
  assign host_irq   = (|(pci_irq_status & pci_host_irq_mask))
                      & (|pci_host_irq_enable);

  // interrupt gate
  // Registered so the pin never glitches on mixed input edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      pci_inta_req <= 1'b0;
    end else if (!if_r.intr_en) begin
      pci_inta_req <= 1'b0;
    end else if (if_r.intr_host_sel) begin
      pci_inta_req <= host_irq;
    end else begin
      pci_inta_req <= client_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(reg_addr, `OFS_BYTESWAP)) begin
      rd_mux = bs_r;
    end else if (hit(reg_addr, `OFS_REV)) begin
      rd_mux = {24'h00_0000, VER_LEVEL, REV_LEVEL};
    end else if (hit(reg_addr, `OFS_IF_CTL)) begin
      rd_mux = {16'h0000, if_r};
    end
  end

  // Data one cycle after the read strobe; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rd_mux : 32'h0000_0000;
      reg_rvalid <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence nmi_write_one;
    reg_wr && hit(reg_addr, `OFS_NMI) && reg_wdata[`NMI_TRIG_BIT];
  endsequence

  sequence nmi_single;
    cpu_nmi_pulse ##1 !cpu_nmi_pulse;
  endsequence

  nmi_pulse_a: assert property (nmi_write_one ##1 !reg_wr |-> nmi_single)
    else $error("NMI pulse missing or too long");

  nmi_cause_a: assert property (cpu_nmi_pulse |-> $past(wr_nmi))
    else $error("NMI pulse without a write");

  nmi_read_a: assert property (
    reg_rd && hit(reg_addr, `OFS_NMI) |=> reg_rdata == 32'h0000_0000)
    else $error("NMI register read nonzero");

  bs_reserved_a: assert property ((bs_r & ~`BYTESWAP_MASK) == 32'h0)
    else $error("Byteswap reserved bit set");

  bs_write_a: assert property (
    wr_bs |=> bs_r == ($past(reg_wdata) & `BYTESWAP_MASK))
    else $error("Byteswap write not stored");

  // Reset drives the hold value, so check at the first edge with reset low
  cpu_endian_a: assert property (
    $fell(rst) |-> swap_ctl.cpu_big_endian == `CPU_BIG_END_RST)
    else $error("CPU endian reset value wrong");

  endian_follow_a: assert property (
    $fell(rst) |-> swap_ctl.lbus_swap == swap_ctl.cpu_big_endian
      && swap_ctl.enet_swap == swap_ctl.cpu_big_endian
      && swap_ctl.pci_ep_swap == swap_ctl.cpu_big_endian
      && swap_ctl.cpu_flash_swap == swap_ctl.cpu_big_endian)
    else $error("Endian-default fields differ after reset");

  zero_reset_a: assert property (
    $fell(rst) |-> !swap_ctl.sdram_big_endian && !swap_ctl.wbuf_full_merge
      && !swap_ctl.pci_tgt_swap && !swap_ctl.cpu_dram_swap)
    else $error("Zero-reset byteswap field set");

  // Load is taken at the third edge after release, seen at the fourth
  sequence strap_fill;
    $fell(rst) ##2 1'b1;
  endsequence

  strap_enable_a: assert property (
    strap_fill |=> if_r.if_enable == strap_if_enable($past(mode_sync_r)))
    else $error("Interface enable not loaded from strap");

  strap_host_a: assert property (
    strap_fill |=> if_r.pci_host == &$past(mode_sync_r)
      && if_r.lbus_host == $past(eep_sync_r))
    else $error("Host bits not loaded from strap");

  host_guard_a: assert property (
    strap_st_r == ST_RUN && wr_if && reg_wdata[`IF_HOST_BIT] && !pci_available
      |=> if_r.pci_host == $past(if_r.pci_host))
    else $error("PCI host set while unavailable");

  inta_off_a: assert property (!if_r.intr_en |=> !pci_inta_req)
    else $error("Interrupt raised while disabled");

  inta_sel_a: assert property (
    if_r.intr_en |=> pci_inta_req ==
      ($past(if_r.intr_host_sel) ? $past(host_irq) : $past(client_irq)))
    else $error("Interrupt source wrong");

  timeout_a: assert property (
    wr_if && strap_st_r == ST_RUN |=> apb_timeout_en == !$past(reg_wdata[14]))
    else $error("Timeout enable does not follow bit 14");

  obs_sel_a: assert property (
    wr_if && strap_st_r == ST_RUN |=> if_r.ahb_obs_sel == $past(reg_wdata[10:8])
      && if_r.dsl_obs_sel == $past(reg_wdata[7:6])
      && if_r.apb_obs_sel == $past(reg_wdata[13:11]))
    else $error("Observation select not stored");

endmodule

// ---- cpu_bus_model.sv ----
// Purpose: Register bus master standing in for the processor side.
// Assumes: Strobes are one-cycle pulses; read answer comes one cycle later.
// Notes:   Released address and data are inverted so stale use shows up.
`timescale 1ns/10ps

module cpu_bus_model (
  input  wire logic        mclk,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus from time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hFF;
    reg_wdata = 32'h0;
  end

  // Drop the bus; inverted lines, never the last value
  task automatic release_bus();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // One write, launched just after an edge, taken at the next
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    release_bus();
  endtask

  // One read; answer is registered, so it stands right after the taking edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge mclk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
    v = reg_rvalid;
    release_bus();
  endtask
endmodule

// ---- test_endian_and_interface_config_regs.sv ----
// Purpose: Self-checking bench for the endian and interface config block.
// Assumes: Bus master model drives the register port; bench drives straps.
// Notes:   Straps change only across a reset, as board wiring would.
`timescale 1ns/10ps
`include "sysctl_defs.svh"

module test_endian_and_interface_config_regs
  import sysctl_pkg::*;
();
  logic        mclk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic [1:0]  mode_strap;
  logic        eeprom_en_strap;
  logic        pci_available;
  logic [31:0] irq_stat;
  logic [31:0] irq_mask;
  logic [31:0] host_stat;
  logic [31:0] host_mask;
  logic [31:0] host_en;
  swap_ctl_t   swap_ctl;
  if_ctl_t     if_ctl;
  logic        cpu_nmi_pulse;
  logic        pci_inta_req;
  logic        apb_timeout_en;
  int          miscompares;
  int          samples_checked;
  int          cycles;

  sysctl_cfg sysctl_cfg_inst (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mode_strap(mode_strap), .eeprom_en_strap(eeprom_en_strap),
    .pci_available(pci_available), .global_irq_status(irq_stat), .client_irq_mask(irq_mask),
    .pci_irq_status(host_stat), .pci_host_irq_mask(host_mask), .pci_host_irq_enable(host_en),
    .swap_ctl(swap_ctl), .if_ctl(if_ctl), .cpu_nmi_pulse(cpu_nmi_pulse),
    .pci_inta_req(pci_inta_req), .apb_timeout_en(apb_timeout_en)
  );

  cpu_bus_model cpu_bus_model_inst (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Read through the master, answer must be flagged valid
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic v;
    cpu_bus_model_inst.rd(a, d, v);
    check({31'h0, v}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, read-only and unmapped places
  task automatic t_reset_values();
    logic [31:0] d;
    rd(`OFS_BYTESWAP, d);
    check(d, 32'h0000_8468);
    check({20'h0, swap_ctl}, 32'h12D);
    check({31'h0, apb_timeout_en}, 32'h1);
    check({31'h0, pci_inta_req}, 32'h0);
    rd(`OFS_NMI, d);
    check(d, 32'h0);
    cpu_bus_model_inst.wr(`OFS_REV, 32'hFFFF_FFFF);
    rd(`OFS_REV, d);
    check(d, 32'h21);
    cpu_bus_model_inst.wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, d);
    check(d, 32'h0);
  endtask

  // Each byteswap field alone, then all ones against reserved bits
  task automatic t_swap_fields();
    int          pos [12] = '{3, 4, 5, 6, 9, 10, 11, 12, 15, 16, 17, 18};
    logic [31:0] d;
    for (int i = 0; i < 12; i++) begin
      cpu_bus_model_inst.wr(`OFS_BYTESWAP, 32'h1 << pos[i]);
      check({20'h0, swap_ctl}, 32'h1 << i);
      rd(`OFS_BYTESWAP, d);
      check(d, 32'h1 << pos[i]);
    end
    cpu_bus_model_inst.wr(`OFS_BYTESWAP, 32'hFFFF_FFFF);
    rd(`OFS_BYTESWAP, d);
    check(d, 32'h0007_9E78);
  endtask

  // single pulse on one, none on zero
  task automatic t_nmi();
    cpu_bus_model_inst.wr(`OFS_NMI, 32'h1);
    check({31'h0, cpu_nmi_pulse}, 32'h1);
    @(posedge mclk);
    #1;
    check({31'h0, cpu_nmi_pulse}, 32'h0);
    cpu_bus_model_inst.wr(`OFS_NMI, 32'hFFFF_FFFE);
    check({31'h0, cpu_nmi_pulse}, 32'h0);
  endtask

  // strap loading over every strap code
  task automatic t_straps();
    logic [2:0] map [4] = '{3'h1, 3'h2, 3'h0, 3'h1};
    for (int s = 0; s < 4; s++) begin
      mode_strap      = s[1:0];
      eeprom_en_strap = ~s[0];
      rst             = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      check({29'h0, if_ctl.if_enable}, {29'h0, map[s]});
      check({31'h0, if_ctl.lbus_host}, {31'h0, ~s[0]});
      check({31'h0, if_ctl.pci_host}, {31'h0, s[1] & s[0]});
    end
  endtask

  // Interface control fields, host gate and every enable code
  task automatic t_if_ctl();
    logic [31:0] d;
    // host write needs availability; bit 4 cleared first so a one would show
    pci_available = 1'b0;
    cpu_bus_model_inst.wr(`OFS_IF_CTL, 32'h0);
    cpu_bus_model_inst.wr(`OFS_IF_CTL, 32'hFFFF_FFFF);
    rd(`OFS_IF_CTL, d);
    check(d, 32'h0000_FFEF);
    check({31'h0, apb_timeout_en}, 32'h0);
    pci_available = 1'b1;
    cpu_bus_model_inst.wr(`OFS_IF_CTL, 32'hFFFF_FFFF);
    check({16'h0, if_ctl}, 32'hFFFF);
    for (int c = 0; c < 8; c++) begin
      cpu_bus_model_inst.wr(`OFS_IF_CTL, c);
      rd(`OFS_IF_CTL, d);
      check(d, c);
      check({31'h0, apb_timeout_en}, 32'h1);
    end
  endtask

  // interrupt gate; sources are client status, client mask, host status
  // host mask and host enable, msb first
  task automatic t_inta();
    logic [15:0] ctl [7] = '{16'h0, 16'h20, 16'h20, 16'h8020, 16'h8020, 16'h8020, 16'h8000};
    logic [4:0]  src [7] = '{5'h1F, 5'h18, 5'h17, 5'h18, 5'h06, 5'h07, 5'h1F};
    logic        ex  [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      cpu_bus_model_inst.wr(`OFS_IF_CTL, {16'h0, ctl[i]});
      irq_stat  = {31'h0, src[i][4]};
      irq_mask  = {31'h0, src[i][3]};
      host_stat = {29'h0, src[i][2], 2'h0};
      host_mask = {29'h0, src[i][1], 2'h0};
      host_en   = {31'h0, src[i][0]};
      repeat (2) @(posedge mclk);
      #1;
      check({31'h0, pci_inta_req}, {31'h0, ex[i]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    miscompares     = 0;
    samples_checked = 0;
    cycles          = 0;
    rst             = 1'b1;
    mode_strap      = 2'h0;
    eeprom_en_strap = 1'b0;
    pci_available   = 1'b1;
    irq_stat        = 32'h0;
    irq_mask        = 32'h0;
    host_stat       = 32'h0;
    host_mask       = 32'h0;
    host_en         = 32'h0;
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge mclk);
    t_reset_values();
    t_swap_fields();
    t_nmi();
    t_straps();
    t_if_ctl();
    t_inta();
    summarize();
  end
endmodule
